// [verilog/sdram_cfg_pkg.sv]
// Constants shared by the configuration logic of a synchronous DRAM and its controller.
// Assumes a single rising-edge clock shared by both ends.
package sdram_cfg_pkg;
  // ---------------------------------------------------------------------------
  // Command encoding (cs_n, ras_n, cas_n, we_n)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam logic [3:0] CMD_LOAD   = 4'h0;
  localparam logic [3:0] CMD_DESEL  = 4'hF;
  // ---------------------------------------------------------------------------
  // Standard configuration fields
  // ---------------------------------------------------------------------------
  localparam int BL_LSB       = 0;
  localparam int ORDER_BIT    = 3;
  localparam int LAT_LSB      = 4;
  localparam int OPMODE_LSB   = 7;
  localparam int WSINGLE_BIT  = 9;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [11:0] STD_RESET = 12'h022;
  // ---------------------------------------------------------------------------
  // Extended configuration fields
  // ---------------------------------------------------------------------------
  localparam int PARTIAL_ARRAY_REFRESH_LSB     = 0;
  localparam int TCR_LSB      = 3;
  localparam int DRIVE_LSB    = 5;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_ALL  = 3'h0;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_TWO  = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_ONE  = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_HALF = 3'h5;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_QTR  = 3'h6;
  localparam logic [11:0] EXT_RESET = 12'h000;
  localparam logic [1:0] SEL_STD = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int RECOVERY_CLKS = 2;
  localparam logic [7:0] RECOVERY_CNT = 8'(RECOVERY_CLKS);
  // ---------------------------------------------------------------------------
  // Controller register map (AXI4-Lite byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
endpackage

// [verilog/sdram_link_if.sv]
// Link between the memory configuration logic and its controller.
// Assumes both ends run on the same clock; the testbench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [11:0] addr;
  logic [15:0] dq_ctl;
  logic        dq_ctl_oe_n;
  logic [15:0] dq_mem;
  logic        dq_mem_oe_n;
  logic [15:0] dq_in;
  modport mem  (input cmd, bank, addr, dq_in, output dq_mem, dq_mem_oe_n);
  modport ctrl (output cmd, bank, addr, dq_ctl, dq_ctl_oe_n, input dq_in);
endinterface
`default_nettype wire

// [verilog/burst_seq.sv]
// Column sequencer for one burst: offset within an aligned block.
// Assumes len_code is one of the four supported burst lengths.
`timescale 1ns/1ps
`default_nettype none
module burst_seq
(
  input  wire logic [8:0] start_col,
  input  wire logic [2:0] step,
  input  wire logic [2:0] len_code,
  input  wire logic       interleaved,
  output var  logic [8:0] col
);
  logic [2:0] mask;
  logic [2:0] ofs;
  always_comb
  begin
    case (len_code)
      sdram_cfg_pkg::BL_2: mask = 3'h1;
      sdram_cfg_pkg::BL_4: mask = 3'h3;
      sdram_cfg_pkg::BL_8: mask = 3'h7;
      default:             mask = 3'h0;
    endcase
    if (interleaved)
      ofs = start_col[2:0] ^ step; // R8
    else
      ofs = 3'(start_col[2:0] + step); // R7
    col = {start_col[8:3], (start_col[2:0] & ~mask) | (ofs & mask)}; // R5 R6
  end
endmodule // burst_seq
`default_nettype wire

// [verilog/sdram_cfg_mem.sv]
// Configuration logic of the memory device: two configuration registers, burst
// sequencing and read-data timing. Assumes the controller keeps command spacing.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Decode standard word fields per bit ranges.
// R2: Standard contents held until next load.
// R3: Controller loads only idle, then waits recovery.
// R4: Burst lengths one, two, four, eight.
// R5: Burst wraps inside aligned length-sized block.
// R6: Low column bits give start position.
// R7: Sequential order increments modulo length.
// R8: Interleaved order XORs start with counter.
// R9: Read latency two or three clocks.
// R10: Drive from n+m-1, valid at n+m.
// R11: Controller programs operating mode zero.
// R12: Single-location bit makes writes length one.
// R13: Controller never programs reserved encodings.
// R14: Extended load only idle, then recovery wait.
// R15: Extended contents survive deep power-down.
// R16: Temperature refresh bits have no effect.
// R17: Five partial-array refresh region options.
// R18: Access all banks; self refresh region only.
// R19: Drive strength from extended bits five, six.
// R20: Bank select picks standard or extended register.
// R21: Latency codes 010 and 011.
// R22: Partial-array codes 000,001,010,101,110.
module sdram_cfg_mem
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  sdram_link_if.mem        link,
  input  wire logic        self_refresh,
  output logic [11:0]      std_cfg,
  output logic [11:0]      ext_cfg,
  output logic [1:0]       drive_strength,
  output logic [3:0]       refresh_banks,
  output logic [1:0]       refresh_row_msbs,
  output logic             col_valid,
  output logic             col_write,
  output logic [1:0]       col_bank,
  output logic [8:0]       col_addr,
  output logic             cfg_error
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] std_cfg;
    logic [11:0] ext_cfg;
    logic        active;
    logic        is_write;
    logic [1:0]  bank;
    logic [8:0]  start;
    logic [2:0]  step;
    logic [2:0]  len;
    logic        order;
    logic        lat3;
    logic [3:0]  rd_pipe;
    logic [3:0]  banks;
    logic [1:0]  row_msbs;
    logic        col_valid;
    logic        col_write;
    logic [1:0]  col_bank;
    logic [8:0]  col_addr;
    logic [15:0] dq;
    logic        dq_oe_n;
    logic        err;
  } mem_state_s;
  mem_state_s st_reg;
  mem_state_s st_next;
  logic [8:0] seq_col;
  logic [2:0] last_step;
  // ---------------------------------------------------------------------------
  // Column sequencer
  // ---------------------------------------------------------------------------
  burst_seq i_burst_seq
  (
    .start_col   (st_reg.start),
    .step        (st_reg.step),
    .len_code    (st_reg.len),
    .interleaved (st_reg.order),
    .col         (seq_col)
  );
  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    case (st_reg.len)
      sdram_cfg_pkg::BL_2: last_step = 3'h1;
      sdram_cfg_pkg::BL_4: last_step = 3'h3;
      sdram_cfg_pkg::BL_8: last_step = 3'h7;
      default:             last_step = 3'h0; // R4
    endcase
    st_next.col_valid = st_reg.active;
    st_next.col_write = st_reg.is_write;
    st_next.col_bank  = st_reg.bank;
    st_next.col_addr  = seq_col;
    if (st_reg.active)
    begin
      if (st_reg.step == last_step)
        st_next.active = 1'b0;
      st_next.step = 3'(st_reg.step + 3'h1);
    end
    // Read data lanes: pipe bit 0 marks the edge at which driving starts.
    st_next.rd_pipe = {1'b0, st_reg.rd_pipe[3:1]};
    if (st_reg.rd_pipe[0])
      st_next.dq_oe_n = 1'b0; // R10
    else if (!st_reg.active && !st_reg.col_valid)
      st_next.dq_oe_n = 1'b1;
    // At latency three the column word lags one cycle, so the first word lands at n+m.
    if (st_reg.lat3)
      st_next.dq = {7'h00, st_reg.col_addr}; // R9
    else
      st_next.dq = {7'h00, seq_col};
    // -------------------------------------------------------------------------
    // Commands
    // -------------------------------------------------------------------------
    case (link.cmd)
      sdram_cfg_pkg::CMD_LOAD:
      begin
        if (link.bank == sdram_cfg_pkg::SEL_STD)
        begin
          st_next.std_cfg = link.addr; // R2 R20
          st_next.err = link.addr[11:10] != 2'h0
                        || link.addr[sdram_cfg_pkg::OPMODE_LSB +: 2] != 2'h0; // R1 R11
        end
        else if (link.bank == sdram_cfg_pkg::SEL_EXT)
          st_next.ext_cfg = link.addr; // R15 R20
      end
      sdram_cfg_pkg::CMD_READ, sdram_cfg_pkg::CMD_WRITE:
      begin
        st_next.active   = 1'b1;
        st_next.is_write = link.cmd == sdram_cfg_pkg::CMD_WRITE;
        st_next.bank     = link.bank; // R18
        st_next.start    = link.addr[8:0]; // R6
        st_next.step     = 3'h0;
        st_next.order    = st_reg.std_cfg[sdram_cfg_pkg::ORDER_BIT];
        st_next.len      = st_reg.std_cfg[sdram_cfg_pkg::BL_LSB +: 3];
        if (link.cmd == sdram_cfg_pkg::CMD_WRITE
            && st_reg.std_cfg[sdram_cfg_pkg::WSINGLE_BIT])
          st_next.len = sdram_cfg_pkg::BL_1; // R12
        if (link.cmd == sdram_cfg_pkg::CMD_READ)
        begin
          st_next.lat3 = st_reg.std_cfg[sdram_cfg_pkg::LAT_LSB +: 3] == sdram_cfg_pkg::LAT_3;
          if (st_reg.std_cfg[sdram_cfg_pkg::LAT_LSB +: 3] == sdram_cfg_pkg::LAT_3)
            st_next.rd_pipe = 4'h2; // R9 R21
          else
            st_next.rd_pipe = 4'h1; // R9 R21
        end
      end
      default:
      begin
      end
    endcase
    // -------------------------------------------------------------------------
    // Refresh region
    // -------------------------------------------------------------------------
    // Temperature bits are stored but deliberately never decoded.
    st_next.banks    = 4'hF; // R16
    st_next.row_msbs = 2'h0;
    if (self_refresh)
    begin
      case (st_reg.ext_cfg[sdram_cfg_pkg::PARTIAL_ARRAY_REFRESH_LSB +: 3]) // R17 R22
        sdram_cfg_pkg::PARTIAL_ARRAY_REFRESH_TWO:  st_next.banks = 4'h3;
        sdram_cfg_pkg::PARTIAL_ARRAY_REFRESH_ONE:  st_next.banks = 4'h1;
        sdram_cfg_pkg::PARTIAL_ARRAY_REFRESH_HALF:
        begin
          st_next.banks    = 4'h1;
          st_next.row_msbs = 2'h1;
        end
        sdram_cfg_pkg::PARTIAL_ARRAY_REFRESH_QTR:
        begin
          st_next.banks    = 4'h1;
          st_next.row_msbs = 2'h2;
        end
        default:                  st_next.banks = 4'hF; // R18
      endcase
    end
  end
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg         <= '0;
      st_reg.std_cfg <= sdram_cfg_pkg::STD_RESET;
      st_reg.ext_cfg <= sdram_cfg_pkg::EXT_RESET;
      st_reg.banks   <= 4'hF;
      st_reg.dq_oe_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end
  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign std_cfg          = st_reg.std_cfg;
  assign ext_cfg          = st_reg.ext_cfg;
  assign drive_strength   = st_reg.ext_cfg[sdram_cfg_pkg::DRIVE_LSB +: 2]; // R19
  assign refresh_banks    = st_reg.banks;
  assign refresh_row_msbs = st_reg.row_msbs;
  assign col_valid        = st_reg.col_valid;
  assign col_write        = st_reg.col_write;
  assign col_bank         = st_reg.col_bank;
  assign col_addr         = st_reg.col_addr;
  assign cfg_error        = st_reg.err;
  assign link.dq_mem      = st_reg.dq;
  assign link.dq_mem_oe_n = st_reg.dq_oe_n;
endmodule // sdram_cfg_mem
`default_nettype wire

// [verilog/sdram_cfg_ctrl.sv]
// Controller end: takes orders over AXI4-Lite and issues link commands.
// Assumes the link partner is the configuration logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_ctrl
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  sdram_link_if.ctrl       link,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw;
    logic        w_got;
    logic [31:0] w;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [15:0] rcap;
    logic [3:0]  cmd;
    logic [7:0]  wait_cnt;
    logic [2:0]  cap_cnt;
    logic        lat3;
    logic        oe_n;
  } ctrl_state_s;
  ctrl_state_s st_reg;
  ctrl_state_s st_next;
  always_comb
  begin
    st_next = st_reg;
    st_next.cmd = sdram_cfg_pkg::CMD_NOP;
    st_next.oe_n = 1'b1;
    if (st_reg.wait_cnt != 8'h00)
      st_next.wait_cnt = 8'(st_reg.wait_cnt - 8'h01); // R3 R14
    // The first read word is taken at n+m; a released data wire is never sampled.
    if (st_reg.cap_cnt != 3'h0)
      st_next.cap_cnt = 3'(st_reg.cap_cnt - 3'h1);
    if (st_reg.cap_cnt == 3'h1)
      st_next.rcap = link.dq_in; // R10
    if (s_axi_awvalid && !st_reg.aw_got)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got)
    begin
      st_next.w_got = 1'b1;
      st_next.w = s_axi_wdata;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid
        && (st_reg.aw != sdram_cfg_pkg::OFS_CMD || st_reg.wait_cnt == 8'h00))
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'h0;
      case (st_reg.aw)
        sdram_cfg_pkg::OFS_CMD:
        begin
          st_next.cmd = st_reg.w[3:0];
          if (st_reg.w[3:0] == sdram_cfg_pkg::CMD_LOAD)
            st_next.wait_cnt = sdram_cfg_pkg::RECOVERY_CNT; // R3 R14
          if (st_reg.w[3:0] == sdram_cfg_pkg::CMD_WRITE)
            st_next.oe_n = 1'b0;
          if (st_reg.w[3:0] == sdram_cfg_pkg::CMD_READ)
            st_next.cap_cnt = st_reg.lat3 ? 3'h4 : 3'h3; // R9
          if (st_reg.w[3:0] == sdram_cfg_pkg::CMD_LOAD
              && st_reg.addr[13:12] == sdram_cfg_pkg::SEL_STD)
            st_next.lat3 = st_reg.addr[sdram_cfg_pkg::LAT_LSB +: 3] == sdram_cfg_pkg::LAT_3;
        end
        sdram_cfg_pkg::OFS_ADDR:  st_next.addr = st_reg.w[13:0];
        sdram_cfg_pkg::OFS_WDATA: st_next.wdata = st_reg.w[15:0];
        default:                  st_next.bresp = 2'h2;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'h0;
      case (s_axi_araddr)
        sdram_cfg_pkg::OFS_ADDR:   st_next.rdata = {18'h0, st_reg.addr};
        sdram_cfg_pkg::OFS_WDATA:  st_next.rdata = {16'h0000, st_reg.wdata};
        sdram_cfg_pkg::OFS_STATUS: st_next.rdata = {31'h0, st_reg.wait_cnt != 8'h00};
        sdram_cfg_pkg::OFS_RDATA:  st_next.rdata = {16'h0000, st_reg.rcap};
        default:
        begin
          st_next.rdata = sdram_cfg_pkg::BAD_ADDR_DATA;
          st_next.rresp = 2'h2;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg      <= '0;
      st_reg.cmd  <= sdram_cfg_pkg::CMD_NOP;
      st_reg.oe_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end
  assign s_axi_awready    = !st_reg.aw_got;
  assign s_axi_wready     = !st_reg.w_got;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_arready    = !st_reg.rvalid;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rdata      = st_reg.rdata;
  assign s_axi_rresp      = st_reg.rresp;
  assign link.cmd         = st_reg.cmd;
  assign link.bank        = st_reg.addr[13:12]; // R20
  assign link.addr        = st_reg.addr[11:0]; // R1 R11 R13
  assign link.dq_ctl      = st_reg.wdata;
  assign link.dq_ctl_oe_n = st_reg.oe_n;
endmodule // sdram_cfg_ctrl
`default_nettype wire

// [verification/sdram_mode_config_props.sv]
// Assertions on the link between controller and memory configuration logic.
// Assumes one clock and a synchronous active-high reset; the bench instantiates it.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_config_props
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  cmd,
  input wire logic [1:0]  bank,
  input wire logic [11:0] addr,
  input wire logic        dq_ctl_oe_n,
  input wire logic        dq_mem_oe_n
);
  logic [2:0] lat_reg;
  logic       rd;
  logic       ld;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Follows the latency field of the last standard load.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lat_reg <= sdram_cfg_pkg::STD_RESET[6:4];
    else if (ld && bank == sdram_cfg_pkg::SEL_STD)
      lat_reg <= addr[6:4];
  end
  assign rd = cmd == sdram_cfg_pkg::CMD_READ && dq_mem_oe_n;
  assign ld = cmd == sdram_cfg_pkg::CMD_LOAD;
  property p_rst_idle;
    $fell(sys_rst) |-> cmd == sdram_cfg_pkg::CMD_NOP && dq_mem_oe_n;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
  property p_lat2;
    rd && lat_reg != sdram_cfg_pkg::LAT_3 |=> dq_mem_oe_n ##1 !dq_mem_oe_n;
  endproperty
  a_lat2: assert property (p_lat2) else $error("no drive at latency two");
  property p_lat3;
    rd && lat_reg == sdram_cfg_pkg::LAT_3 |-> ##2 dq_mem_oe_n ##1 !dq_mem_oe_n;
  endproperty
  a_lat3: assert property (p_lat3) else $error("wrong drive at latency three");
  property p_recovery;
    ld |=> (cmd == sdram_cfg_pkg::CMD_NOP)[*2];
  endproperty
  a_recovery: assert property (p_recovery) else $error("command during recovery");
  property p_load_idle;
    ld |-> dq_mem_oe_n && dq_ctl_oe_n;
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("load during data transfer");
  property p_one_driver;
    !dq_mem_oe_n |-> dq_ctl_oe_n;
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  property p_write_quiet;
    cmd == sdram_cfg_pkg::CMD_WRITE && dq_mem_oe_n |=> dq_mem_oe_n[*3];
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("memory drives on write");
  property p_load_bank;
    ld |-> bank == sdram_cfg_pkg::SEL_STD || bank == sdram_cfg_pkg::SEL_EXT;
  endproperty
  a_load_bank: assert property (p_load_bank) else $error("load to reserved bank");
endmodule // sdram_mode_config_props
`default_nettype wire

// [verification/sdram_mode_config_tb_top.sv]
// Bench joining controller and memory configuration logic across the link.
// Assumes package, interface and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_config_tb_top;
  logic        clk;
  logic        sys_rst;
  logic        self_refresh;
  logic [11:0] std_cfg, ext_cfg;
  logic [1:0]  drive_strength, refresh_row_msbs, col_bank;
  logic [3:0]  refresh_banks, s_axi_wstrb;
  logic        col_valid, col_write, cfg_error;
  logic [8:0]  col_addr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] dq_last = 16'h0000;
  logic [11:0] cols[$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  sdram_link_if i_sdram_link_if ();
  sdram_cfg_mem i_sdram_cfg_mem (.clk, .sys_rst, .link(i_sdram_link_if), .self_refresh,
    .std_cfg, .ext_cfg, .drive_strength, .refresh_banks, .refresh_row_msbs, .col_valid,
    .col_write, .col_bank, .col_addr, .cfg_error);
  sdram_cfg_ctrl i_sdram_cfg_ctrl (.clk, .sys_rst, .link(i_sdram_link_if), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sdram_mode_config_props i_sdram_mode_config_props (.clk, .sys_rst, .cmd(i_sdram_link_if.cmd),
    .bank(i_sdram_link_if.bank), .addr(i_sdram_link_if.addr),
    .dq_ctl_oe_n(i_sdram_link_if.dq_ctl_oe_n), .dq_mem_oe_n(i_sdram_link_if.dq_mem_oe_n));
  // An undriven data wire shows the inverse of its last level.
  assign i_sdram_link_if.dq_in = !i_sdram_link_if.dq_mem_oe_n ? i_sdram_link_if.dq_mem :
    !i_sdram_link_if.dq_ctl_oe_n ? i_sdram_link_if.dq_ctl : ~dq_last;
  always @(posedge clk)
  begin
    dq_last <= i_sdram_link_if.dq_in;
    if (col_valid === 1'b1)
      cols.push_back({col_bank, col_write, col_addr});
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    logic [1:0] r;
    axi_wr(sdram_cfg_pkg::OFS_ADDR, 32'({b, a}), r);
    axi_wr(sdram_cfg_pkg::OFS_CMD, 32'(c), r);
    chk(16'(r), 16'h0, "bresp");
  endtask
  // Issues one access at start column 0x0A5 of bank 3 and judges every column.
  task automatic run(input logic [3:0] c, input logic [11:0] v, input int n);
    logic [8:0] m;
    logic [15:0] e;
    logic [31:0] d;
    logic [1:0] r;
    m = 9'(n - 1);
    cols.delete();
    issue(c, 2'h3, 12'h0A5);
    repeat (16) @(posedge clk);
    chk(16'(cols.size()), 16'(n), "burst length");
    for (int i = 0; i < cols.size(); i++)
    begin
      e = {4'h0, 2'h3, c == sdram_cfg_pkg::CMD_WRITE, (9'h0A5 & ~m)};
      if (v[3])
        chk(16'(cols[i]), e | 16'((9'h0A5 ^ 9'(i)) & m), "interleaved");
      else
        chk(16'(cols[i]), e | 16'((9'h0A5 + 9'(i)) & m), "sequential");
    end
    if (c == sdram_cfg_pkg::CMD_READ)
    begin
      axi_rd(sdram_cfg_pkg::OFS_RDATA, d, r);
      chk(d[15:0], 16'h00A5, "first read word");
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h20, d, r);
    chk(16'(r), 16'h2, "read resp");
    chk(d[15:0], 16'h0, "read data");
    axi_wr(8'h24, 32'h1, r);
    chk(16'(r), 16'h2, "write resp");
    axi_wr(sdram_cfg_pkg::OFS_WDATA, 32'h1234_ABCD, r);
    axi_rd(sdram_cfg_pkg::OFS_WDATA, d, r);
    chk(d[15:0], 16'hABCD, "wdata readback");
    axi_rd(sdram_cfg_pkg::OFS_STATUS, d, r);
    chk(d[15:0], 16'h0000, "status idle");
  endtask
  task automatic t_ext;
    logic [2:0] pc [5] = '{3'h0, 3'h2, 3'h5, 3'h6, 3'h1};
    logic [3:0] eb [5] = '{4'hF, 4'h1, 4'h1, 4'h1, 4'h3};
    logic [1:0] er [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [11:0] v;
    for (int i = 0; i < 5; i++)
    begin
      v = {5'h0, 2'(i), 2'h3, pc[i]};
      issue(sdram_cfg_pkg::CMD_LOAD, sdram_cfg_pkg::SEL_EXT, v);
      self_refresh <= 1'b1;
      repeat (3) @(posedge clk);
      chk(16'(ext_cfg), 16'(v), "extended word");
      chk(16'(drive_strength), 16'(v[6:5]), "drive");
      chk(16'(refresh_banks), 16'(eb[i]), "refresh banks");
      chk(16'(refresh_row_msbs), 16'(er[i]), "refresh rows");
      self_refresh <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk(16'(refresh_banks), 16'hF, "awake banks");
    chk(16'(std_cfg), 16'(sdram_cfg_pkg::STD_RESET), "standard kept");
  endtask
  // Every burst length in both orders; odd entries use latency three.
  task automatic t_burst;
    logic [11:0] v;
    for (int k = 0; k < 8; k++)
    begin
      v = {5'h0, 3'(2 + k % 2), 1'(k % 2), 3'(k / 2)};
      issue(sdram_cfg_pkg::CMD_LOAD, sdram_cfg_pkg::SEL_STD, v);
      run(sdram_cfg_pkg::CMD_READ, v, 1 << (k / 2));
      chk(16'(std_cfg), 16'(v), "standard word");
      chk(16'(cfg_error), 16'h0, "mode clean");
    end
  endtask
  task automatic t_write;
    logic [11:0] v;
    for (int s = 0; s < 2; s++)
    begin
      v = {2'h0, 1'(s), 5'h02, 4'hA};
      issue(sdram_cfg_pkg::CMD_LOAD, sdram_cfg_pkg::SEL_STD, v);
      run(sdram_cfg_pkg::CMD_WRITE, v, s ? 1 : 4);
      run(sdram_cfg_pkg::CMD_READ, v, 4);
    end
    issue(sdram_cfg_pkg::CMD_LOAD, sdram_cfg_pkg::SEL_STD, 12'h0A2);
    repeat (3) @(posedge clk);
    chk(16'(cfg_error), 16'h1, "mode flagged");
  endtask
  initial
  begin
    {sys_rst, self_refresh, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    self_refresh = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(16'(std_cfg), 16'(sdram_cfg_pkg::STD_RESET), "standard reset");
    chk(16'(ext_cfg), 16'(sdram_cfg_pkg::EXT_RESET), "extended reset");
    t_bus();
    t_ext();
    t_burst();
    t_write();
    end_sim();
  end
endmodule // sdram_mode_config_tb_top
`default_nettype wire
